// *** shared/sbst_map.svh ***
// constants for the memory boundary-scan test port
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH
`define SBST_IR_W        3
`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDCODE   3'h1
`define SBST_IR_SAMPZ    3'h2
`define SBST_IR_SAMPLE   3'h4
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAPTURE  2'h1
`define SBST_ID_W        32
// identification value is arbitrary, bit 0 set as the standard asks
`define SBST_IDCODE      32'h0A5A_5001
`define SBST_BSR_W       16
`define SBST_BSR_OE_BIT  15
`define SBST_BSR_RST     16'h8000
`endif

// *** shared/sbst_pkg.sv ***
// types shared by the boundary-scan test port
`include "sbst_map.svh"
package sbst_pkg;
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } sbst_state_e;
    typedef enum logic [1:0] {SEL_BYP, SEL_ID, SEL_BSR} sbst_sel_e;
    typedef logic [`SBST_IR_W-1:0] sbst_ir_t;
    typedef logic [`SBST_BSR_W-1:0] sbst_bsr_t;
    // state clocked on the rising test-clock edge
    typedef struct packed {
        sbst_ir_t              ir;
        sbst_ir_t              ir_sh;
        logic                  byp;
        logic [`SBST_ID_W-1:0] id_sh;
        sbst_bsr_t             bsr_sh;
        sbst_bsr_t             bsr_upd;
        logic                  upd_tgl;
    } sbst_rise_s;
    // state clocked on the falling test-clock edge
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } sbst_fall_s;
    // word handed from the test clock to the system clock
    typedef struct packed {
        logic      extest;
        logic      hiz;
        sbst_bsr_t bsr;
    } sbst_xfer_s;
    // system-clock state
    typedef struct packed {
        logic       tgl_seen;
        sbst_xfer_s xfer;
    } sbst_ref_s;
endpackage : sbst_pkg

// *** hdl/sbst_sync.sv ***
// two-flop synchroniser with asynchronous clear
`timescale 1ns/10ps
`default_nettype none
module sbst_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,   // destination clock
    input  wire logic             rst_b_i, // async clear, active low
    input  wire logic [WIDTH-1:0] d_i,     // level from another domain
    output logic      [WIDTH-1:0] q_o      // synchronised level
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : sbst_sync
`default_nettype wire

// *** hdl/sbst_tap_fsm.sv ***
// sixteen-state test controller
`timescale 1ns/10ps
`default_nettype none
module sbst_tap_fsm
    import sbst_pkg::*;
(
    input  wire logic  tck_i,       // test clock
    input  wire logic  rst_b_i,     // async reset, active low
    input  wire logic  ce_i,        // clock enable
    input  wire logic  tms_i,       // mode-select as seen at the pin
    output sbst_state_e state_o,    // current state
    output sbst_state_e state_nxt_o // state after this edge
);
    // next state from the mode-select level
    always_comb begin
        state_nxt_o = state_o;
        if (ce_i) begin
            unique case (state_o)
                ST_RESET:  state_nxt_o = tms_i ? ST_RESET  : ST_IDLE;
                ST_IDLE:   state_nxt_o = tms_i ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: state_nxt_o = tms_i ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: state_nxt_o = tms_i ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR:  state_nxt_o = tms_i ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: state_nxt_o = tms_i ? ST_UPD_DR : ST_PAU_DR;
                ST_PAU_DR: state_nxt_o = tms_i ? ST_EX2_DR : ST_PAU_DR;
                ST_EX2_DR: state_nxt_o = tms_i ? ST_UPD_DR : ST_SH_DR;
                ST_UPD_DR: state_nxt_o = tms_i ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: state_nxt_o = tms_i ? ST_RESET  : ST_CAP_IR;
                ST_CAP_IR: state_nxt_o = tms_i ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR:  state_nxt_o = tms_i ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: state_nxt_o = tms_i ? ST_UPD_IR : ST_PAU_IR;
                ST_PAU_IR: state_nxt_o = tms_i ? ST_EX2_IR : ST_PAU_IR;
                ST_EX2_IR: state_nxt_o = tms_i ? ST_UPD_IR : ST_SH_IR;
                ST_UPD_IR: state_nxt_o = tms_i ? ST_SEL_DR : ST_IDLE;
            endcase
        end
    end

    // state register, sampled on the rising edge
    always_ff @(posedge tck_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_o <= ST_RESET;
        end else begin
            state_o <= state_nxt_o;
        end
    end
endmodule : sbst_tap_fsm
`default_nettype wire

// *** hdl/sbst_tap.sv ***
// boundary-scan test port of the memory, top level
`timescale 1ns/10ps
`default_nettype none
`include "sbst_map.svh"
module sbst_tap
    import sbst_pkg::*;
(
    input  wire logic      ref_clk_i,   // system clock, 10 MHz
    input  wire logic      rst_b_i,     // power-up reset, active low
    input  wire logic      ce_i,        // clock enable, freezes state when low
    input  wire logic      tck_i,       // test clock from the tester
    input  wire logic      tms_i,       // mode-select level
    input  wire logic      tms_drv_i,   // high while the board drives mode-select
    input  wire logic      tdi_i,       // serial data in level
    input  wire logic      tdi_drv_i,   // high while the board drives data in
    input  wire sbst_bsr_t mem_pins_i,  // memory ring levels to capture
    output logic           tdo_o,       // serial data out
    output logic           tdo_oe_o,    // serial data out driver enable
    output logic           mem_hiz_o,   // forces memory outputs to high-Z
    output logic           extest_o,    // ring outputs take scan values
    output sbst_bsr_t      bscan_out_o  // scan values for the ring outputs
);
    ////////////////////////////////////////////////////////////////
    // resets and crossings
    ////////////////////////////////////////////////////////////////
    logic [1:0]  rst_pipe_r;
    logic        rst_ref_b;
    logic        rst_tck_b;
    logic        ce_tck;
    logic        tgl_ref;
    sbst_bsr_t   pins_tck;

    // release the system reset through two flops
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_ref_b = rst_pipe_r[1];

    // test-side reset: asserts at once, releases on the test clock
    sbst_sync u_trst (
        .clk_i   (tck_i),
        .rst_b_i (rst_ref_b),
        .d_i     (1'b1),
        .q_o     (rst_tck_b)
    );

    // clock enable carried into the test clock domain
    sbst_sync u_ce (
        .clk_i   (tck_i),
        .rst_b_i (rst_tck_b),
        .d_i     (ce_i),
        .q_o     (ce_tck)
    );

    // memory ring levels caught on the test clock
    sbst_sync #(.WIDTH(`SBST_BSR_W)) u_pins (
        .clk_i   (tck_i),
        .rst_b_i (rst_tck_b),
        .d_i     (mem_pins_i),
        .q_o     (pins_tck)
    );

    ////////////////////////////////////////////////////////////////
    // controller and instruction decode
    ////////////////////////////////////////////////////////////////
    logic        tms_eff;
    logic        tdi_eff;
    sbst_state_e state;
    sbst_state_e state_nxt;
    sbst_sel_e   sel;
    logic        shifting;
    sbst_rise_s  rs_r;
    sbst_rise_s  rs_nxt;
    sbst_fall_s  fs_r;
    sbst_fall_s  fs_nxt;
    sbst_xfer_s  xfer_tck;

    // undriven balls read as pulled high
    assign tms_eff = tms_drv_i ? tms_i : 1'b1;
    assign tdi_eff = tdi_drv_i ? tdi_i : 1'b1;

    sbst_tap_fsm u_fsm (
        .tck_i       (tck_i),
        .rst_b_i     (rst_tck_b),
        .ce_i        (ce_tck),
        .tms_i       (tms_eff),
        .state_o     (state),
        .state_nxt_o (state_nxt)
    );

    // the held instruction picks one data register
    always_comb begin
        unique case (rs_r.ir)
            `SBST_IR_IDCODE: sel = SEL_ID;
            `SBST_IR_EXTEST,
            `SBST_IR_SAMPZ,
            `SBST_IR_SAMPLE: sel = SEL_BSR;
            default:         sel = SEL_BYP; // bypass and unused codes
        endcase
    end

    assign shifting = (state == ST_SH_DR) || (state == ST_SH_IR);

    ////////////////////////////////////////////////////////////////
    // serial registers, rising edge
    ////////////////////////////////////////////////////////////////
    // capture, shift and update of the scan registers
    always_comb begin
        rs_nxt = rs_r;
        if (ce_tck) begin
            unique case (state)
                ST_CAP_IR: rs_nxt.ir_sh = {1'b0, `SBST_IR_CAPTURE};
                ST_SH_IR:  rs_nxt.ir_sh = {tdi_eff, rs_r.ir_sh[`SBST_IR_W-1:1]};
                ST_UPD_IR: begin
                    rs_nxt.ir      = rs_r.ir_sh;
                    rs_nxt.upd_tgl = ~rs_r.upd_tgl;
                end
                ST_CAP_DR: begin
                    unique case (sel)
                        SEL_ID:  rs_nxt.id_sh  = `SBST_IDCODE;
                        SEL_BSR: rs_nxt.bsr_sh = pins_tck;
                        default: rs_nxt.byp    = 1'b0;
                    endcase
                end
                ST_SH_DR: begin
                    unique case (sel)
                        SEL_ID:  rs_nxt.id_sh  = {tdi_eff, rs_r.id_sh[`SBST_ID_W-1:1]};
                        SEL_BSR: rs_nxt.bsr_sh = {tdi_eff, rs_r.bsr_sh[`SBST_BSR_W-1:1]};
                        default: rs_nxt.byp    = tdi_eff;
                    endcase
                end
                ST_UPD_DR: begin
                    if ((rs_r.ir == `SBST_IR_SAMPLE) || (rs_r.ir == `SBST_IR_EXTEST)) begin
                        rs_nxt.bsr_upd = rs_r.bsr_sh;
                        rs_nxt.upd_tgl = ~rs_r.upd_tgl;
                    end
                end
                default: ;
            endcase
            // any move into reset restores instruction and preload
            if (state_nxt == ST_RESET) begin
                rs_nxt.ir      = `SBST_IR_IDCODE;
                rs_nxt.bsr_upd = `SBST_BSR_RST;
                if (state != ST_RESET) begin
                    rs_nxt.upd_tgl = ~rs_r.upd_tgl;
                end
            end
        end
    end

    // rising-edge register of the scan state
    always_ff @(posedge tck_i or negedge rst_tck_b) begin
        if (!rst_tck_b) begin
            rs_r         <= '0;
            rs_r.ir      <= `SBST_IR_IDCODE;
            rs_r.bsr_upd <= `SBST_BSR_RST;
        end else begin
            rs_r <= rs_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // serial output, falling edge
    ////////////////////////////////////////////////////////////////
    // lsb of the register in the path, driven only while shifting
    always_comb begin
        fs_nxt = fs_r;
        if (ce_tck) begin
            fs_nxt.tdo_oe = shifting;
            if (state == ST_SH_IR) begin
                fs_nxt.tdo = rs_r.ir_sh[0];
            end else if (state == ST_SH_DR) begin
                unique case (sel)
                    SEL_ID:  fs_nxt.tdo = rs_r.id_sh[0];
                    SEL_BSR: fs_nxt.tdo = rs_r.bsr_sh[0];
                    default: fs_nxt.tdo = rs_r.byp;
                endcase
            end
        end
    end

    // falling-edge register of the output
    always_ff @(negedge tck_i or negedge rst_tck_b) begin
        if (!rst_tck_b) begin
            fs_r <= '0;
        end else begin
            fs_r <= fs_nxt;
        end
    end
    assign tdo_o    = fs_r.tdo;
    assign tdo_oe_o = fs_r.tdo_oe;

    ////////////////////////////////////////////////////////////////
    // hand-over to the system clock
    ////////////////////////////////////////////////////////////////
    sbst_ref_s ref_r;
    sbst_ref_s ref_nxt;

    // memory pins are touched only by extest and sample-z
    always_comb begin
        xfer_tck.extest = (rs_r.ir == `SBST_IR_EXTEST);
        xfer_tck.hiz    = (rs_r.ir == `SBST_IR_SAMPZ) ||
                          (xfer_tck.extest && !rs_r.bsr_upd[`SBST_BSR_OE_BIT]);
        xfer_tck.bsr    = rs_r.bsr_upd;
    end

    // toggle announces a settled word
    sbst_sync u_tgl (
        .clk_i   (ref_clk_i),
        .rst_b_i (rst_ref_b),
        .d_i     (rs_r.upd_tgl),
        .q_o     (tgl_ref)
    );

    // take the word once per toggle
    always_comb begin
        ref_nxt = ref_r;
        if (ce_i && (tgl_ref != ref_r.tgl_seen)) begin
            ref_nxt.tgl_seen = tgl_ref;
            ref_nxt.xfer     = xfer_tck;
        end
    end

    // system-side register, memory runs untouched by port reset
    always_ff @(posedge ref_clk_i or negedge rst_ref_b) begin
        if (!rst_ref_b) begin
            ref_r          <= '0;
            ref_r.xfer.bsr <= `SBST_BSR_RST;
        end else begin
            ref_r <= ref_nxt;
        end
    end
    assign mem_hiz_o   = ref_r.xfer.hiz;
    assign extest_o    = ref_r.xfer.extest;
    assign bscan_out_o = ref_r.xfer.bsr;

    ////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////
    sequence s_tms_hold;
        (tms_eff && ce_tck) [*5];
    endsequence

    sequence s_shift_byp;
        (state == ST_SH_DR) && (sel == SEL_BYP) && ce_tck;
    endsequence

    property p_five_reset;
        @(posedge tck_i) disable iff (!rst_tck_b)
        s_tms_hold |=> (state == ST_RESET);
    endproperty
    a_five_reset: assert property (p_five_reset)
        else $error("five high mode-select edges did not reset");

    property p_oe_shift;
        @(posedge tck_i) disable iff (!rst_tck_b)
        tdo_oe_o == shifting;
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("data out enable outside shift states");

    property p_ir_reset;
        @(posedge tck_i) disable iff (!rst_tck_b)
        (state == ST_RESET) |-> (rs_r.ir == `SBST_IR_IDCODE);
    endproperty
    a_ir_reset: assert property (p_ir_reset)
        else $error("instruction not identification in reset");

    property p_cap_ir;
        @(posedge tck_i) disable iff (!rst_tck_b)
        ((state == ST_CAP_IR) && ce_tck) |=> (rs_r.ir_sh[1:0] == `SBST_IR_CAPTURE);
    endproperty
    a_cap_ir: assert property (p_cap_ir)
        else $error("instruction capture pattern wrong");

    property p_ir_hold;
        @(posedge tck_i) disable iff (!rst_tck_b)
        ((state != ST_UPD_IR) && (state_nxt != ST_RESET)) |=> $stable(rs_r.ir);
    endproperty
    a_ir_hold: assert property (p_ir_hold)
        else $error("instruction changed outside update");

    property p_bypass;
        @(posedge tck_i) disable iff (!rst_tck_b)
        s_shift_byp ##1 s_shift_byp |-> (tdo_o == $past(tdi_eff, 1))
            ##1 ((state != ST_SH_DR) || !ce_tck || (tdo_o == $past(tdi_eff, 1)));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass path is not one stage");

    property p_id_cap;
        @(posedge tck_i) disable iff (!rst_tck_b)
        ((state == ST_CAP_DR) && (sel == SEL_ID) && ce_tck) |=>
            (rs_r.id_sh == `SBST_IDCODE);
    endproperty
    a_id_cap: assert property (p_id_cap)
        else $error("identification code not captured");

    property p_msb_in;
        @(posedge tck_i) disable iff (!rst_tck_b)
        ((state == ST_SH_DR) && (sel == SEL_BSR) && ce_tck) |=>
            (rs_r.bsr_sh == {$past(tdi_eff), $past(rs_r.bsr_sh[`SBST_BSR_W-1:1])});
    endproperty
    a_msb_in: assert property (p_msb_in)
        else $error("scan data not entering at msb");

    property p_tdo_lsb;
        @(posedge tck_i) disable iff (!rst_tck_b)
        ((state == ST_SH_DR) && (sel == SEL_ID)) |-> (tdo_o == rs_r.id_sh[0]);
    endproperty
    a_tdo_lsb: assert property (p_tdo_lsb)
        else $error("data out not from selected lsb");
endmodule : sbst_tap
`default_nettype wire

// *** tb/sbst_jtag_host.sv ***
// board-side test controller model that drives the test port
`timescale 1ns/10ps
`default_nettype none
module sbst_jtag_host (
    output logic      tck_o,     // test clock, parked low
    output logic      tms_o,     // mode-select level
    output logic      tms_drv_o, // mode-select driven
    output logic      tdi_o,     // serial data in level
    output logic      tdi_drv_o, // serial data in driven
    input  wire logic tdo_i,     // serial data out, never driven here
    input  wire logic tdo_oe_i   // serial data out enable
);
    ////////////////////////////////////////////////////////////////////////////////
    // clock stands still low between frames, lines start driven high
    initial begin
        tck_o     = 1'b0;
        tms_o     = 1'b1;
        tms_drv_o = 1'b1;
        tdi_o     = 1'b1;
        tdi_drv_o = 1'b1;
    end

    // one test-clock period; a released line toggles so only the pull-up decides
    task automatic step(input logic tms, input logic tdi, input logic drv,
                        output logic tdo, output logic oe);
        tms_drv_o = drv;
        tdi_drv_o = drv;
        tms_o     = drv ? tms : ~tms_o;
        tdi_o     = drv ? tdi : ~tdi_o;
        #24;
        tdo   = tdo_oe_i ? tdo_i : ~tdo_i;
        oe    = tdo_oe_i;
        tck_o = 1'b1;
        #24;
        tck_o = 1'b0;
    endtask : step

    // one period with only mode-select of interest
    task automatic go(input logic tms);
        logic a;
        logic b;
        step(tms, 1'b1, 1'b1, a, b);
    endtask : go

    // from idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir_path, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe_all);
        logic oe;
        logic t;
        dout   = 32'h0;
        oe_all = 1'b1;
        go(1'b1);
        if (ir_path)
            go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, t, oe);
            dout[i] = t;
            oe_all  = oe_all & oe;
        end
        go(1'b1);
        go(1'b0);
    endtask : scan

    // mode-select high for five rising edges
    task automatic reset5(input logic drv);
        logic a;
        logic b;
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b1, drv, a, b);
        end
    endtask : reset5
endmodule : sbst_jtag_host
`default_nettype wire

// *** tb/sbst_tap_tb_top.sv ***
// self-checking bench of the memory boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
`include "sbst_map.svh"
module sbst_tap_tb_top
    import sbst_pkg::*;
;
    logic      ref_clk = 1'b0;
    logic      rst_b   = 1'b0;
    logic      ce      = 1'b1;
    sbst_bsr_t pins    = 16'h0000;
    wire logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, mem_hiz, extest;
    sbst_bsr_t bscan;
    int        mismatches;
    int        checks;
    logic [31:0] d;
    logic        oe_all;

    ////////////////////////////////////////////////////////////////////////////////
    // system clock and instances
    always #50 ref_clk = ~ref_clk;

    sbst_tap i_sbst_tap (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .ce_i(ce), .tck_i(tck),
        .tms_i(tms), .tms_drv_i(tms_drv), .tdi_i(tdi), .tdi_drv_i(tdi_drv),
        .mem_pins_i(pins), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .mem_hiz_o(mem_hiz),
        .extest_o(extest), .bscan_out_o(bscan));

    sbst_jtag_host i_sbst_jtag_host (.tck_o(tck), .tms_o(tms), .tms_drv_o(tms_drv),
        .tdi_o(tdi), .tdi_drv_o(tdi_drv), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic stop_test;
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // memory-side word must arrive within eight system cycles
    task automatic wait_mem(input logic e, input logic h, input sbst_bsr_t b);
        logic ok;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge ref_clk);
            ok = (extest === e) && (mem_hiz === h) && (bscan === b);
        end
        check({14'h0, extest, mem_hiz, bscan}, {14'h0, e, h, b});
        if (!ok)
            stop_test();
    endtask : wait_mem

    // scan one register and check the driver was on only while shifting
    task automatic scan(input logic ir, input int n, input logic [31:0] din);
        i_sbst_jtag_host.scan(ir, n, din, d, oe_all);
        check({31'h0, oe_all}, 32'h1);
        check({31'h0, tdo_oe}, 32'h0);
    endtask : scan

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_wake;
        i_sbst_jtag_host.reset5(1'b1);
        i_sbst_jtag_host.reset5(1'b1);
        check({31'h0, tdo_oe}, 32'h0);
        wait_mem(1'b0, 1'b0, `SBST_BSR_RST);
        i_sbst_jtag_host.go(1'b0);
    endtask : t_wake

    task automatic t_idcode;
        scan(1'b0, 32, 32'h0);
        check(d, `SBST_IDCODE);
    endtask : t_idcode

    task automatic t_bypass;
        scan(1'b1, 3, {29'h0, `SBST_IR_BYPASS});
        check(d, 32'h1);
        scan(1'b0, 4, 32'hB);
        check(d, 32'h6);
    endtask : t_bypass

    task automatic t_bsr;
        @(negedge ref_clk);
        pins = 16'h1234;
        scan(1'b1, 3, {29'h0, `SBST_IR_SAMPLE});
        wait_mem(1'b0, 1'b0, `SBST_BSR_RST);
        scan(1'b0, 16, 32'h0);
        check(d, 32'h1234);
        wait_mem(1'b0, 1'b0, 16'h0000);
        scan(1'b1, 3, {29'h0, `SBST_IR_EXTEST});
        wait_mem(1'b1, 1'b1, 16'h0000);
        scan(1'b1, 3, {29'h0, `SBST_IR_SAMPZ});
        wait_mem(1'b0, 1'b1, 16'h0000);
    endtask : t_bsr

    // clock enable low freezes controller and instruction
    task automatic t_freeze;
        @(negedge ref_clk);
        ce = 1'b0;
        repeat (3) i_sbst_jtag_host.go(1'b0);
        i_sbst_jtag_host.reset5(1'b1);
        check({31'h0, tdo_oe}, 32'h0);
        @(negedge ref_clk);
        ce = ~ce;
        repeat (3) i_sbst_jtag_host.go(1'b0);
        wait_mem(1'b0, 1'b1, 16'h0000);
    endtask : t_freeze

    // power-up reset again in mid-run while extest drives the ring
    task automatic t_reset_mid;
        scan(1'b1, 3, {29'h0, `SBST_IR_EXTEST});
        wait_mem(1'b1, 1'b0, `SBST_BSR_RST);
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({31'h0, extest}, 32'h0);
        check({31'h0, tdo_oe}, 32'h0);
        rst_b = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_wake();
    endtask : t_reset_mid

    // reset from mid-shift with mode-select left floating
    task automatic t_tms_reset;
        i_sbst_jtag_host.go(1'b1);
        i_sbst_jtag_host.go(1'b0);
        i_sbst_jtag_host.go(1'b0);
        i_sbst_jtag_host.go(1'b0);
        i_sbst_jtag_host.reset5(1'b0);
        check({31'h0, tdo_oe}, 32'h0);
        wait_mem(1'b0, 1'b0, `SBST_BSR_RST);
        i_sbst_jtag_host.go(1'b0);
    endtask : t_tms_reset

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mismatches = 0;
        checks     = 0;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_wake();
        t_idcode();
        t_bypass();
        t_bsr();
        t_freeze();
        t_tms_reset();
        t_idcode();
        t_reset_mid();
        t_idcode();
        stop_test();
    end
endmodule : sbst_tap_tb_top
`default_nettype wire
